/* core/crth_defs.vh */
`ifndef CRTH_DEFS_VH
`define CRTH_DEFS_VH

// transfer_type encodings (I, C, N, S)
`define CRTH_TT_INT 2'h0
`define CRTH_TT_COP 2'h1
`define CRTH_TT_NSEQ 2'h2
`define CRTH_TT_SEQ 2'h3

// address offsets from the instruction pc
`define CRTH_PC_OFS_WAIT 32'h00000008
`define CRTH_PC_OFS_XFER 32'h0000000c
`define CRTH_VEC_STEP 32'h00000004

// enabled edges from strobe low until the synced answer is seen
`define CRTH_HS_LAT 3'h4

// trap mode and state
`define CRTH_TRAP_MODE 5'h04
`define CRTH_RST_MODE 5'h13
`define CRTH_RST_VEC 32'h00000004

// apb register byte offsets
`define CRTH_REG_CTRL 12'h000
`define CRTH_REG_STAT 12'h004
`define CRTH_REG_IRQ_STAT 12'h008
`define CRTH_REG_IRQ_MASK 12'h00c
`define CRTH_REG_RDATA 12'h010
`define CRTH_REG_WDATA 12'h014

// ctrl register fields
`define CRTH_CTRL_GO 0
`define CRTH_CTRL_DIR 1
`define CRTH_CTRL_COND 2
`define CRTH_CTRL_UNDEF 3
`define CRTH_CTRL_IRQ 4
`define CRTH_CTRL_TSTATE 5

// event bit positions
`define CRTH_EV_DONE 0
`define CRTH_EV_TRAP 1
`define CRTH_EV_ABANDON 2
`define CRTH_EV_SKIP 3
`define CRTH_EV_BKPT 4
`define CRTH_EV_W 5

`endif

/* core/crth_sync2.v */
`timescale 1ns/1ps
// ----------------------------------------
// two-flop synchroniser
// ----------------------------------------
module crth_sync2 #(
    parameter W = 1
) (
    input wire mclk,
    input wire rst_b,
    input wire [W-1:0] rst_val,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta_q;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= {W{1'b1}};
            dout <= {W{1'b1}};
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* core/crth_core.v */
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
// Function
// - capture read word cycle two, write cycle three
// - third cycle may merge with prefetch
// - write source on bus at pc+12
// - busy repeats internal cycles, then coproc cycle
// - interrupt may abandon busy-wait
// - no move-from-coproc in compressed state
// - undefined traps: two cycles, then vector
// - absent coprocessor treated as undefined
// - failed condition takes one sequential cycle
// - write selects read or write bus
// - data buses valid only on transfer cycles
`include "crth_defs.vh"
module crth_core (
    input wire mclk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire irq,
    input wire clock_gate_enable,
    input wire coproc_absent,
    input wire coproc_busy,
    input wire external_breakpoint,
    input wire [31:0] rdata,
    output reg [31:0] addr,
    output reg [31:0] wdata,
    output reg write,
    output reg [1:0] transfer_type,
    output reg coproc_instr_strobe_n,
    output reg prot_opcode_or_data,
    output reg prot_privileged,
    output reg [4:0] cpu_mode,
    output reg tstate
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam S_IDLE = 7'h01;
    localparam S_FIRST = 7'h02;
    localparam S_WAIT = 7'h04;
    localparam S_XFER = 7'h08;
    localparam S_WBACK = 7'h10;
    localparam S_UND2 = 7'h20;
    localparam S_VEC = 7'h40;

    reg [6:0] st_q;
    reg [31:0] pc_q;
    reg [31:0] vec_q;
    reg [31:0] dest_q;
    reg [31:0] src_q;
    reg [2:0] lat_q;
    reg [5:0] ctrl_q;
    reg [5:0] istat_q;
    reg [5:0] imask_q;
    reg go_q;
    reg vec2_q;
    reg [5:0] ev;
    wire [2:0] pins_s;
    wire cp_abs = pins_s[2];
    wire cp_bsy = pins_s[1];
    // breakpoint passes inverted so the sync reset value reads idle
    wire bkpt = ~pins_s[0];
    wire ce = clock_gate_enable;

    function [31:0] pc_plus;
        input [31:0] pc;
        input [31:0] ofs;
        begin
            pc_plus = pc + ofs;
        end
    endfunction

    crth_sync2 #(.W(3)) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .rst_val(3'h7),
        .din({coproc_absent, coproc_busy, ~external_breakpoint}),
        .dout(pins_s)
    );

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = acc & (paddr > `CRTH_REG_WDATA);
    assign irq = |(istat_q & imask_q);

    always @* begin
        case (paddr)
            `CRTH_REG_CTRL: prdata = {26'h0, ctrl_q};
            `CRTH_REG_STAT: prdata = {24'h0, st_q, go_q};
            `CRTH_REG_IRQ_STAT: prdata = {26'h0, istat_q};
            `CRTH_REG_IRQ_MASK: prdata = {26'h0, imask_q};
            `CRTH_REG_RDATA: prdata = dest_q;
            `CRTH_REG_WDATA: prdata = src_q;
            default: prdata = 32'h0;
        endcase
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 6'h0;
            imask_q <= 6'h0;
            src_q <= 32'h0;
            istat_q <= 6'h0;
        end else begin
            if (wr && paddr == `CRTH_REG_CTRL)
                ctrl_q <= pwdata[5:0];
            if (wr && paddr == `CRTH_REG_IRQ_MASK)
                imask_q <= pwdata[5:0];
            if (wr && paddr == `CRTH_REG_WDATA)
                src_q <= pwdata;
            // set wins over read-clear
            if (rd && paddr == `CRTH_REG_IRQ_STAT)
                istat_q <= ev;
            else
                istat_q <= istat_q | ev;
        end
    end

    // ----------------------------------------
    // handshake sequencer
    // ----------------------------------------
    wire is_mrc = ~ctrl_q[`CRTH_CTRL_DIR];
    always @* begin
        ev = 6'h0;
        // breakpoint sampled on an enabled edge
        ev[`CRTH_EV_BKPT] = ce & bkpt;
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= S_IDLE;
            go_q <= 1'b0;
            pc_q <= 32'h0;
            vec_q <= `CRTH_RST_VEC;
            dest_q <= 32'h0;
            lat_q <= 3'h0;
            vec2_q <= 1'b0;
            cpu_mode <= `CRTH_RST_MODE;
            tstate <= 1'b0;
        end else begin
            if (wr && paddr == `CRTH_REG_CTRL && pwdata[`CRTH_CTRL_GO])
                go_q <= 1'b1;
            // state moves only on enabled edges
            if (ce) begin
                case (st_q)
                    S_IDLE: begin
                        lat_q <= 3'h0;
                        if (go_q) begin
                            go_q <= 1'b0;
                            tstate <= ctrl_q[`CRTH_CTRL_TSTATE];
                            st_q <= S_FIRST;
                        end
                    end
                    S_FIRST: begin
                        if (!ctrl_q[`CRTH_CTRL_COND]) begin
                            pc_q <= pc_plus(pc_q, `CRTH_VEC_STEP);
                            st_q <= S_IDLE;
                        end else if (ctrl_q[`CRTH_CTRL_UNDEF] ||
                                     (tstate && is_mrc)) begin
                            st_q <= S_UND2;
                        end else if (lat_q != `CRTH_HS_LAT) begin
                            // wait for the synced answer to arrive
                            lat_q <= lat_q + 3'h1;
                        end else if (cp_abs) begin
                            st_q <= S_UND2;
                        end else if (cp_bsy) begin
                            st_q <= S_WAIT;
                        end else begin
                            st_q <= S_XFER;
                        end
                    end
                    S_WAIT: begin
                        if (ctrl_q[`CRTH_CTRL_IRQ])
                            st_q <= S_IDLE;
                        else if (cp_abs)
                            st_q <= S_UND2;
                        else if (!cp_bsy)
                            st_q <= S_XFER;
                    end
                    S_XFER: begin
                        if (is_mrc) begin
                            st_q <= S_WBACK;
                        end else begin
                            pc_q <= pc_plus(pc_q, `CRTH_VEC_STEP);
                            st_q <= S_IDLE;
                        end
                    end
                    S_WBACK: begin
                        // word of second cycle, written now
                        dest_q <= rdata;
                        pc_q <= pc_plus(pc_q, `CRTH_VEC_STEP);
                        st_q <= S_IDLE;
                    end
                    S_UND2: begin
                        cpu_mode <= `CRTH_TRAP_MODE;
                        tstate <= 1'b0;
                        vec2_q <= 1'b0;
                        st_q <= S_VEC;
                    end
                    S_VEC: begin
                        if (vec2_q) begin
                            pc_q <= pc_plus(vec_q, `CRTH_VEC_STEP);
                            st_q <= S_IDLE;
                        end
                        vec2_q <= 1'b1;
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // bus outputs
    // ----------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            addr <= 32'h0;
            wdata <= 32'h0;
            write <= 1'b0;
            transfer_type <= `CRTH_TT_INT;
            coproc_instr_strobe_n <= 1'b1;
            prot_opcode_or_data <= 1'b0;
            prot_privileged <= 1'b1;
        end else if (ce) begin
            write <= 1'b0;
            coproc_instr_strobe_n <= 1'b1;
            prot_opcode_or_data <= 1'b1;
            prot_privileged <= 1'b1;
            addr <= pc_plus(pc_q, `CRTH_PC_OFS_XFER);
            transfer_type <= `CRTH_TT_INT;
            case (st_q)
                S_FIRST: begin
                    addr <= pc_plus(pc_q, `CRTH_PC_OFS_WAIT);
                    prot_opcode_or_data <= 1'b0;
                    if (!ctrl_q[`CRTH_CTRL_COND]) begin
                        transfer_type <= `CRTH_TT_SEQ;
                    end else if (ctrl_q[`CRTH_CTRL_UNDEF] ||
                                 (tstate && is_mrc) ||
                                 (lat_q == `CRTH_HS_LAT && cp_abs)) begin
                        transfer_type <= `CRTH_TT_NSEQ;
                    end else begin
                        coproc_instr_strobe_n <= 1'b0;
                        if (lat_q == `CRTH_HS_LAT && !cp_bsy)
                            transfer_type <= `CRTH_TT_COP;
                    end
                end
                S_WAIT: begin
                    // internal cycles at pc+8, strobe on
                    addr <= pc_plus(pc_q, `CRTH_PC_OFS_WAIT);
                    coproc_instr_strobe_n <= 1'b0;
                    if (ctrl_q[`CRTH_CTRL_IRQ]) begin
                        coproc_instr_strobe_n <= 1'b1;
                    end else if (cp_abs) begin
                        coproc_instr_strobe_n <= 1'b1;
                        transfer_type <= `CRTH_TT_NSEQ;
                    end else if (!cp_bsy) begin
                        transfer_type <= `CRTH_TT_COP;
                    end
                end
                S_WBACK: begin
                    transfer_type <= `CRTH_TT_SEQ;
                end
                S_UND2: begin
                    addr <= vec_q;
                    transfer_type <= `CRTH_TT_SEQ;
                    prot_opcode_or_data <= 1'b0;
                end
                S_VEC: begin
                    addr <= pc_plus(vec_q, `CRTH_VEC_STEP);
                    transfer_type <= vec2_q ? `CRTH_TT_INT
                                            : `CRTH_TT_SEQ;
                    prot_opcode_or_data <= 1'b0;
                end
                default: ;
            endcase
            if (st_q == S_XFER && !is_mrc) begin
                write <= 1'b1;
                wdata <= src_q;
                transfer_type <= `CRTH_TT_NSEQ;
                addr <= pc_plus(pc_q, `CRTH_PC_OFS_XFER);
            end
        end
    end
endmodule

/* tb/crth_assertions.sv */
`timescale 1ns/1ps
`include "crth_defs.vh"
// ----------------
// handshake checks
// ----------------
module crth_chk (
    input wire mclk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire clock_gate_enable,
    input wire [31:0] addr,
    input wire write,
    input wire [1:0] transfer_type,
    input wire coproc_instr_strobe_n,
    input wire prot_privileged,
    input wire [4:0] cpu_mode,
    input wire tstate
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence cop_s;
        transfer_type == `CRTH_TT_COP && clock_gate_enable;
    endsequence
    sequence trap_s;
        $rose(cpu_mode == `CRTH_TRAP_MODE);
    endsequence
    stall_hold_a: assert property (
        !clock_gate_enable |=> $stable({addr, write, transfer_type}))
        else $error("outputs moved in stall");
    xfer_addr_a: assert property (
        cop_s |=> addr == $past(addr) + `CRTH_VEC_STEP)
        else $error("transfer not at pc+12");
    after_cop_a: assert property (
        cop_s |=> coproc_instr_strobe_n && (write ?
        transfer_type == `CRTH_TT_NSEQ : transfer_type == `CRTH_TT_INT))
        else $error("bad cycle after coproc cycle");
    write_nseq_a: assert property (
        write |-> transfer_type == `CRTH_TT_NSEQ)
        else $error("write outside transfer");
    wait_addr_a: assert property (
        (transfer_type == `CRTH_TT_INT && !coproc_instr_strobe_n)
        ##1 cop_s |-> $stable(addr))
        else $error("coproc cycle left pc+8");
    trap_in_a: assert property (
        trap_s |-> !tstate && prot_privileged && addr == `CRTH_RST_VEC
        && transfer_type == `CRTH_TT_SEQ
        && $past(transfer_type) == `CRTH_TT_NSEQ)
        else $error("bad trap entry");
    trap_next_a: assert property (
        trap_s ##0 clock_gate_enable |=>
        addr == `CRTH_RST_VEC + `CRTH_VEC_STEP)
        else $error("second vector fetch wrong");
    unmapped_a: assert property (
        psel && penable && paddr > `CRTH_REG_WDATA |->
        pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule

bind crth_core crth_chk u_chk (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .clock_gate_enable(clock_gate_enable), .addr(addr), .write(write),
    .transfer_type(transfer_type),
    .coproc_instr_strobe_n(coproc_instr_strobe_n),
    .prot_privileged(prot_privileged), .cpu_mode(cpu_mode),
    .tstate(tstate)
);

/* tb/crth_cop_model.sv */
`timescale 1ns/1ps
`include "crth_defs.vh"
// ----------------
// coprocessor model
// ----------------
module crth_cop_model (
    input wire mclk,
    input wire rst_b,
    input wire clk_en,
    input wire strobe_n,
    input wire [1:0] tt,
    input wire present,
    input wire [3:0] wait_n,
    input wire [31:0] word,
    output reg absent,
    output reg busy,
    output reg [31:0] rdata
);
    reg [3:0] cnt_q;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            absent <= 1'h1;
            busy <= 1'h1;
            cnt_q <= 4'h0;
            rdata <= 32'h0;
        end else if (clk_en) begin
            absent <= strobe_n | !present;
            busy <= strobe_n | !present | (cnt_q < wait_n);
            cnt_q <= strobe_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
            rdata <= (tt == `CRTH_TT_COP) ? word : ~rdata;
        end
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "crth_defs.vh"
// ----------------
// testbench
// ----------------
module tb_top;
    reg mclk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0;
    reg pwrite = 1'h0, cge = 1'h1, bkpt = 1'h0, present = 1'h1;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0, word = 32'h5a0f3c96;
    reg [3:0] wait_n = 4'h0;
    reg [31:0] rd, w_data, w_addr, c_addr, x;
    reg [1:0] w_tt;
    wire [31:0] prdata, addr, wdata, cp_rdata;
    wire pready, pslverr, irq, absent, busy, write, stb_n, pod, ppv, tst;
    wire [1:0] tt;
    wire [4:0] mode;
    integer mismatches = 0, samples_checked = 0, cyc = 0, i, s, s2;
    integer n_cop = 0, n_wr = 0, n_bw = 0, n_seq = 0;

    always #50 mclk = ~mclk;

    crth_core uut (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .clock_gate_enable(cge), .coproc_absent(absent),
        .coproc_busy(busy), .external_breakpoint(bkpt),
        .rdata(cp_rdata), .addr(addr), .wdata(wdata), .write(write),
        .transfer_type(tt), .coproc_instr_strobe_n(stb_n),
        .prot_opcode_or_data(pod), .prot_privileged(ppv),
        .cpu_mode(mode), .tstate(tst)
    );
    crth_cop_model cop (
        .mclk(mclk), .rst_b(rst_b), .clk_en(cge), .strobe_n(stb_n),
        .tt(tt), .present(present), .wait_n(wait_n), .word(word),
        .absent(absent), .busy(busy), .rdata(cp_rdata)
    );

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            results;
        end
        if (rst_b && cge) begin
            if (tt === `CRTH_TT_COP) begin
                n_cop <= n_cop + 1;
                c_addr <= addr;
            end
            if (write === 1'h1) begin
                n_wr <= n_wr + 1;
                w_data <= wdata;
                w_addr <= addr;
                w_tt <= tt;
            end
            if (tt === `CRTH_TT_INT && stb_n === 1'h0)
                n_bw <= n_bw + 1;
            if (tt === `CRTH_TT_SEQ)
                n_seq <= n_seq + 1;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        @(negedge mclk);
        while (pready !== 1'h1) @(negedge mclk);
        rd = prdata;
        @(posedge mclk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task run(input logic [31:0] ctl);
        s = n_seq;
        s2 = n_cop;
        apb(1'h1, `CRTH_REG_CTRL, ctl);
        rd = 32'h1;
        for (i = 0; i < 100 && rd[1:0] !== 2'h2; i = i + 1)
            apb(1'h0, `CRTH_REG_STAT, 32'h0);
        chk(rd[1:0], 2'h2);
        repeat (2) @(posedge mclk);
    endtask

    task pulse;
        @(posedge mclk);
        bkpt <= 1'h1;
        repeat (3) @(posedge mclk);
        bkpt <= 1'h0;
        repeat (5) @(posedge mclk);
    endtask

    task t_reset;
        chk({addr, write, tt, stb_n, tst, irq, mode},
            {32'h0, 1'h0, `CRTH_TT_INT, 1'h1, 1'h0, 1'h0, `CRTH_RST_MODE});
        $display("reset test end");
    endtask

    task t_mrc;
        x = n_wr;
        run(32'h5);
        apb(1'h0, `CRTH_REG_RDATA, 32'h0);
        chk(rd, word);
        chk(n_wr - x, 0);
        $display("move from test end");
    endtask

    task t_mcr;
        wait_n = 4'h4;
        x = n_bw;
        apb(1'h1, `CRTH_REG_WDATA, 32'hc3a50f1e);
        run(32'h7);
        chk(w_data, 32'hc3a50f1e);
        chk(w_tt, `CRTH_TT_NSEQ);
        chk(w_addr, c_addr + 32'h4);
        chk(n_bw - x > 0, 1'h1);
        wait_n = 4'h0;
        $display("move to test end");
    endtask

    task t_cond;
        run(32'h1);
        chk(n_seq - s, 1);
        chk(n_cop - s2, 0);
        $display("condition test end");
    endtask

    task t_stretch;
        word = 32'h0ff0a55a;
        apb(1'h1, `CRTH_REG_CTRL, 32'h5);
        repeat (3) @(posedge mclk);
        cge <= 1'h0;
        @(posedge mclk);
        x = addr;
        repeat (5) @(posedge mclk);
        chk(addr, x);
        cge <= 1'h1;
        run(32'h4);
        apb(1'h0, `CRTH_REG_RDATA, 32'h0);
        chk(rd, word);
        $display("stretch test end");
    endtask

    task t_abandon;
        wait_n = 4'hf;
        run(32'h15);
        chk(n_cop - s2, 0);
        wait_n = 4'h0;
        $display("abandon test end");
    endtask

    task t_irq;
        apb(1'h1, `CRTH_REG_IRQ_MASK, 32'h10);
        pulse;
        chk(irq, 1'h1);
        apb(1'h0, `CRTH_REG_IRQ_STAT, 32'h0);
        chk(rd[4], 1'h1);
        repeat (2) @(posedge mclk);
        chk(irq, 1'h0);
        apb(1'h1, `CRTH_REG_IRQ_MASK, 32'h0);
        pulse;
        chk(irq, 1'h0);
        apb(1'h1, 12'h020, 32'hffffffff);
        apb(1'h0, 12'h020, 32'h0);
        chk(rd, 32'h0);
        $display("interrupt test end");
    endtask

    task t_absent;
        present = 1'h0;
        run(32'h5);
        chk(mode, `CRTH_TRAP_MODE);
        chk(n_cop - s2, 0);
        present = 1'h1;
        $display("absent test end");
    endtask

    task t_tstate;
        word = 32'h13579bdf;
        run(32'h25);
        apb(1'h0, `CRTH_REG_RDATA, 32'h0);
        chk(rd, 32'h0ff0a55a);
        chk(n_cop - s2, 0);
        $display("compressed test end");
    endtask

    task t_undef;
        run(32'h2d);
        chk({mode, ppv, tst}, {`CRTH_TRAP_MODE, 1'h1, 1'h0});
        chk(n_seq - s >= 2, 1'h1);
        $display("undefined test end");
    endtask

    task results;
        $display("mismatches %0d checks %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        t_reset;
        rst_b <= 1'h1;
        t_mrc;
        t_mcr;
        t_cond;
        t_stretch;
        t_abandon;
        t_irq;
        t_absent;
        t_tstate;
        rst_b <= 1'h0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'h1;
        t_undef;
        results;
    end
endmodule
